// >>> ecl_pkg.sv
package ecl_pkg;

    // apb window: paddr[11:10] selects port 0..2 or the loader's own block (3)
    localparam int          APB_AW          = 12;
    localparam logic [1:0]  BLK_LOADER      = 2'h3;
    localparam logic [9:0]  OFF_CTRL        = 10'h000;   // byte 0xC00
    localparam logic [9:0]  OFF_STATUS      = 10'h004;   // byte 0xC04
    localparam int          CTRL_RELOAD_BIT = 0;

    // configuration memory word addresses handled here
    localparam logic [7:0]  WA_SLOT_P1      = 8'h62;
    localparam logic [7:0]  WA_SLOT_P2      = 8'h64;
    localparam logic [7:0]  WA_PWR_P0       = 8'h70;
    localparam logic [7:0]  WA_PWR_P1       = 8'h72;
    localparam logic [7:0]  WA_PWR_P2       = 8'h74;
    localparam logic [7:0]  WA_PM_P0        = 8'h80;
    localparam logic [7:0]  WA_PM_P1        = 8'h82;
    localparam logic [7:0]  WA_PM_P2        = 8'h84;

    // word slots in the local word store
    localparam logic [2:0]  WS_SLOT_P1      = 3'h0;
    localparam logic [2:0]  WS_SLOT_P2      = 3'h1;
    localparam logic [2:0]  WS_PWR_P0       = 3'h2;
    localparam logic [2:0]  WS_PWR_P1       = 3'h3;
    localparam logic [2:0]  WS_PWR_P2       = 3'h4;
    localparam logic [2:0]  WS_PM_P0        = 3'h5;
    localparam logic [2:0]  WS_PM_P1        = 3'h6;
    localparam logic [2:0]  WS_PM_P2        = 3'h7;
    localparam int          WS_DEPTH        = 8;

    // per-port configuration offsets fed by the loader
    localparam logic [9:0]  CFG_PMCAP       = 10'h040;
    localparam logic [9:0]  CFG_VGA         = 10'h070;
    localparam logic [9:0]  CFG_PMCTL       = 10'h074;
    localparam logic [9:0]  CFG_VTUNE       = 10'h088;
    localparam logic [9:0]  CFG_SLOTCAP     = 10'h0C0;
    localparam logic [9:0]  CFG_PORTNUM     = 10'h0CC;
    localparam logic [9:0]  CFG_SLOTCLK     = 10'h0D0;
    localparam logic [9:0]  CFG_LPVC        = 10'h144;
    localparam logic [9:0]  CFG_TCMAP       = 10'h154;
    localparam logic [9:0]  CFG_PBUDGET     = 10'h214;
    localparam logic [9:0]  CFG_PBALLOC     = 10'h218;

    // field positions: destination bit of each mapped field
    localparam int          DST_SLOT_IMPL   = 24;
    localparam int          DST_SLOT_CLK    = 28;
    localparam int          DST_DSI         = 21;
    localparam int          DST_LPVC        = 4;
    localparam int          DST_PORTNUM     = 24;
    localparam int          DST_TCMAP       = 1;
    localparam int          DST_BASE_PWR    = 0;
    localparam int          DST_DSCALE      = 8;
    localparam int          DST_PMSTATE     = 13;
    localparam int          DST_SYS_ALLOC   = 0;
    localparam int          DST_PMCTL       = 8;
    localparam int          DST_RXPOL_DIS   = 14;
    localparam int          DST_VGA_EN      = 31;
    localparam int          DST_VTUNE       = 24;

    // value used for a word never delivered by the memory
    localparam logic [15:0] WORD_DEFAULT    = 16'h0000;

endpackage

// >>> ecl_word_mem.sv
`timescale 1ns/1ns
`default_nettype none
module ecl_word_mem
(
    // clock
    input  wire logic        clk,
    // write side, fed by the loader
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_idx,
    input  wire logic [15:0] wr_word,
    // read side, registered data
    input  wire logic [2:0]  rd_idx,
    output logic      [15:0] rd_word
);

    logic [15:0] mem_r [ecl_pkg::WS_DEPTH];

    // no reset on the array: validity is tracked by the owner
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem_r[wr_idx] <= wr_word;
        end
        rd_word <= mem_r[rd_idx];
    end

endmodule
`default_nettype wire

// >>> ecl_scatter.sv
`timescale 1ns/1ns
`default_nettype none
module ecl_scatter
(
    // destination offset within the port
    input  wire logic [9:0]  offset,
    // raw memory word
    input  wire logic [15:0] word,
    // register image
    output logic      [31:0] image
);

    // each offset takes its bits from one word only
    always_comb
    begin
        image = 32'h00000000;
        case (offset)
            ecl_pkg::CFG_SLOTCAP:
                image[ecl_pkg::DST_SLOT_IMPL] = word[0];                      // [R1]
            ecl_pkg::CFG_SLOTCLK:
                image[ecl_pkg::DST_SLOT_CLK] = word[1];                       // [R2]
            ecl_pkg::CFG_PMCAP:
                image[ecl_pkg::DST_DSI] = word[2];                            // [R3]
            ecl_pkg::CFG_LPVC:
                image[ecl_pkg::DST_LPVC] = word[3];                           // [R4]
            ecl_pkg::CFG_PORTNUM:
                image[ecl_pkg::DST_PORTNUM +: 3] = word[6:4];                 // [R5]
            ecl_pkg::CFG_TCMAP:
                image[ecl_pkg::DST_TCMAP +: 7] = word[15:9];                  // [R6]
            ecl_pkg::CFG_PBUDGET:
            begin
                image[ecl_pkg::DST_BASE_PWR +: 8] = word[7:0];                // [R7]
                image[ecl_pkg::DST_DSCALE +: 2] = word[9:8];                  // [R8]
                image[ecl_pkg::DST_PMSTATE +: 2] = word[11:10];               // [R8]
            end
            ecl_pkg::CFG_PBALLOC:
                image[ecl_pkg::DST_SYS_ALLOC] = word[15];                     // [R9]
            ecl_pkg::CFG_PMCTL:
            begin
                // d3-to-l1 [1:0], l1 delay [3:2], l0s enable [5:4] kept as one field
                image[ecl_pkg::DST_PMCTL +: 6] = word[5:0];                   // [R10] [R11]
                image[ecl_pkg::DST_RXPOL_DIS] = word[6];                      // [R12]
            end
            ecl_pkg::CFG_VGA:
                image[ecl_pkg::DST_VGA_EN] = word[7];                         // [R13]
            ecl_pkg::CFG_VTUNE:
                image[ecl_pkg::DST_VTUNE +: 8] = word[15:8];                  // [R14]
            default:
                image = 32'h00000000;
        endcase
    end

endmodule
`default_nettype wire

// >>> ecl_loader.sv
// How it works
// R1: word 64h bit0 sets port2 slot implemented
// R2: word 64h bit1 sets port2 slot clock
// R3: word 64h bit2 sets port2 init required
// R4: word 64h bit3 sets port2 low-priority VC1
// R5: word 64h bits6:4 give port2 logical number
// R6: slot word bits15:9 map TCs onto VC0
// R7: power words give per-port base power
// R8: power words give data scale and state
// R9: power word bit15 marks system allocated
// R10: PM words bits5:0 load control parameter
// R11: parameter holds L1 entry, delay, L0s
// R12: PM word bit6 disables rx polarity
// R13: PM word bit7 enables legacy VGA decode
// R14: PM word bits15:8 load vendor tuning
// R15: load done before config accesses; absent words default
// R16: each word scatters to its one port
`timescale 1ns/1ns
`default_nettype none
module ecl_loader
(
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         resetn,
    // words from the configuration memory reader
    input  wire logic                         word_valid,
    input  wire logic [7:0]                   word_addr,
    input  wire logic [15:0]                  word_data,
    input  wire logic                         load_end,
    // loader state
    output logic                              loading,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ecl_pkg::APB_AW-1:0]   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic                              pready,
    output logic      [31:0]                  prdata,
    output logic                              pslverr
);

    // apb answer sequencer states
    typedef enum logic [1:0]
    {
        ECL_IDLE = 2'b00,
        ECL_WAIT = 2'b01,
        ECL_DONE = 2'b10
    } ecl_apb_st_t;

    // word address to store slot; bit 3 flags a handled word
    function automatic logic [3:0] ecl_word_slot(input logic [7:0] a);
        case (a)
            ecl_pkg::WA_SLOT_P1: ecl_word_slot = {1'b1, ecl_pkg::WS_SLOT_P1};
            ecl_pkg::WA_SLOT_P2: ecl_word_slot = {1'b1, ecl_pkg::WS_SLOT_P2};
            ecl_pkg::WA_PWR_P0:  ecl_word_slot = {1'b1, ecl_pkg::WS_PWR_P0};
            ecl_pkg::WA_PWR_P1:  ecl_word_slot = {1'b1, ecl_pkg::WS_PWR_P1};
            ecl_pkg::WA_PWR_P2:  ecl_word_slot = {1'b1, ecl_pkg::WS_PWR_P2};
            ecl_pkg::WA_PM_P0:   ecl_word_slot = {1'b1, ecl_pkg::WS_PM_P0};
            ecl_pkg::WA_PM_P1:   ecl_word_slot = {1'b1, ecl_pkg::WS_PM_P1};
            ecl_pkg::WA_PM_P2:   ecl_word_slot = {1'b1, ecl_pkg::WS_PM_P2};
            default:             ecl_word_slot = 4'h0;
        endcase
    endfunction

    // port and offset to the single word that feeds it
    function automatic logic [3:0] ecl_cfg_slot(input logic [1:0] p, input logic [9:0] o);
        logic [3:0] r;
        r = 4'h0;
        case (o)
            ecl_pkg::CFG_PBUDGET, ecl_pkg::CFG_PBALLOC:
                case (p)
                    2'h0:    r = {1'b1, ecl_pkg::WS_PWR_P0};
                    2'h1:    r = {1'b1, ecl_pkg::WS_PWR_P1};
                    2'h2:    r = {1'b1, ecl_pkg::WS_PWR_P2};
                    default: r = 4'h0;
                endcase
            ecl_pkg::CFG_PMCTL, ecl_pkg::CFG_VGA, ecl_pkg::CFG_VTUNE:
                case (p)
                    2'h0:    r = {1'b1, ecl_pkg::WS_PM_P0};
                    2'h1:    r = {1'b1, ecl_pkg::WS_PM_P1};
                    2'h2:    r = {1'b1, ecl_pkg::WS_PM_P2};
                    default: r = 4'h0;
                endcase
            // port 0 has no slot word
            ecl_pkg::CFG_TCMAP:
                case (p)
                    2'h1:    r = {1'b1, ecl_pkg::WS_SLOT_P1};
                    2'h2:    r = {1'b1, ecl_pkg::WS_SLOT_P2};
                    default: r = 4'h0;
                endcase
            // only port 2 owns these bits
            ecl_pkg::CFG_SLOTCAP, ecl_pkg::CFG_SLOTCLK, ecl_pkg::CFG_PMCAP,
            ecl_pkg::CFG_LPVC, ecl_pkg::CFG_PORTNUM:
                r = (p == 2'h2) ? {1'b1, ecl_pkg::WS_SLOT_P2} : 4'h0;
            default:
                r = 4'h0;
        endcase
        ecl_cfg_slot = r;
    endfunction

    // loader state
    logic                 loading_r;
    logic                 loading_nxt;
    logic [7:0]           wvalid_r;
    logic [7:0]           wvalid_nxt;
    logic [7:0]           wcount_r;
    logic [7:0]           wcount_nxt;

    // apb state
    ecl_apb_st_t          st_r;
    ecl_apb_st_t          st_nxt;
    logic                 pready_r;
    logic [31:0]          prdata_r;
    logic                 pslverr_r;
    logic [31:0]          rdata_nxt;
    logic                 err_nxt;

    // incoming word decode
    // unhandled addresses drop out
    wire  [3:0]           in_slot   = ecl_word_slot(word_addr);
    wire                  in_take   = word_valid && loading_r && in_slot[3];    // [R16]
    wire  [7:0]           in_onehot = 8'h01 << in_slot[2:0];

    // register access decode
    // store read adds one wait
    wire  [1:0]           acc_blk   = paddr[11:10];
    wire  [9:0]           acc_off   = paddr[9:0];
    wire                  acc_own   = (acc_blk == ecl_pkg::BLK_LOADER);
    wire  [3:0]           acc_slot  = ecl_cfg_slot(acc_blk, acc_off);
    wire                  acc_start = psel && !penable;
    wire                  acc_last  = psel && penable && pready_r;
    wire                  own_ctrl  = acc_own && (acc_off == ecl_pkg::OFF_CTRL);
    wire                  own_stat  = acc_own && (acc_off == ecl_pkg::OFF_STATUS);
    wire                  reload    = acc_last && pwrite && own_ctrl
                                      && pwdata[ecl_pkg::CTRL_RELOAD_BIT];

    // store and scatter
    // undelivered words read default
    logic [15:0]          mem_word;
    logic [31:0]          image;
    wire                  word_ok   = acc_slot[3] && wvalid_r[acc_slot[2:0]];
    wire  [15:0]          eff_word  = word_ok ? mem_word : ecl_pkg::WORD_DEFAULT;  // [R15]

    ecl_word_mem u_mem
    (
        .clk     (clk),
        .wr_en   (in_take),
        .wr_idx  (in_slot[2:0]),
        .wr_word (word_data),
        .rd_idx  (acc_slot[2:0]),
        .rd_word (mem_word)
    );

    // scatter is plain logic
    ecl_scatter u_scatter
    (
        .offset (acc_off),
        .word   (eff_word),
        .image  (image)
    );

    // loader bookkeeping; reload drops every loaded word back to default
    always_comb
    begin
        loading_nxt = loading_r;
        wvalid_nxt  = wvalid_r;
        wcount_nxt  = wcount_r;
        if (reload)
        begin
            // a word landing with the reload is kept: set wins
            loading_nxt = 1'b1;
            wvalid_nxt  = in_take ? in_onehot : 8'h00;
            wcount_nxt  = {7'h00, in_take};
        end
        else if (loading_r)
        begin
            if (in_take)
            begin
                wvalid_nxt = wvalid_r | in_onehot;
                wcount_nxt = wcount_r + 8'h01;
            end
            // a word with load_end counts
            if (load_end)
            begin
                loading_nxt = 1'b0;                                             // [R15]
            end
        end
    end

    // read image and error for the current access
    always_comb
    begin
        rdata_nxt = 32'h00000000;
        err_nxt   = 1'b0;
        if (acc_own)
        begin
            // status reads load state, ctrl reads zero, rest fail
            if (own_stat)
            begin
                rdata_nxt = {8'h00, wcount_r, wvalid_r, 7'h00, loading_r};
            end
            else if (!own_ctrl)
            begin
                err_nxt = 1'b1;
            end
        end
        else
        begin
            // config space is read only; unmapped offsets read zero
            rdata_nxt = image;
        end
    end

    // apb: setup, one cycle for the store read, then answer; config accesses held while loading
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            // setup opens an access
            ECL_IDLE:
                st_nxt = acc_start ? ECL_WAIT : ECL_IDLE;
            // config waits out the load
            ECL_WAIT:
                if (!psel)
                begin
                    st_nxt = ECL_IDLE;
                end
                else if (penable && (!loading_r || acc_own))                   // [R15]
                begin
                    st_nxt = ECL_DONE;
                end
            // answer lasts one cycle
            ECL_DONE:
                st_nxt = ECL_IDLE;
            default:
                st_nxt = ECL_IDLE;
        endcase
    end

    // answer decode; prdata stays zero off the answer
    wire                  ans_now   = (st_nxt == ECL_DONE);
    wire  [31:0]          ans_data  = (ans_now && !pwrite) ? rdata_nxt : 32'h00000000;

    // loading flag
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            loading_r <= 1'b1;
        end
        else
        begin
            loading_r <= loading_nxt;
        end
    end

    // word valid mask
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wvalid_r <= 8'h00;
        end
        else
        begin
            wvalid_r <= wvalid_nxt;
        end
    end

    // words taken
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wcount_r <= 8'h00;
        end
        else
        begin
            wcount_r <= wcount_nxt;
        end
    end

    // sequencer state
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_r <= ECL_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ready pulse
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pready_r <= 1'b0;
        end
        else
        begin
            pready_r <= ans_now;
        end
    end

    // read data
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            prdata_r <= 32'h00000000;
        end
        else
        begin
            prdata_r <= ans_data;
        end
    end

    // error, only with ready
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pslverr_r <= 1'b0;
        end
        else
        begin
            pslverr_r <= ans_now && err_nxt;
        end
    end

    // outputs straight from flops
    assign loading = loading_r;
    assign pready  = pready_r;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

endmodule
`default_nettype wire

// >>> ecl_loader_props.sv
`timescale 1ns/1ns
`default_nettype none
module ecl_loader_props
(
    // clock and reset
    input wire logic                       clk,
    input wire logic                       resetn,
    // word stream and loader state
    input wire logic                       word_valid,
    input wire logic [7:0]                 word_addr,
    input wire logic [15:0]                word_data,
    input wire logic                       load_end,
    input wire logic                       loading,
    // apb
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [ecl_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic                       pready,
    input wire logic [31:0]                prdata,
    input wire logic                       pslverr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // shadow of the port 2 slot word; a reload forgets it like the store does
    logic        reload_w;
    logic [15:0] w64_r;
    assign reload_w = pready && psel && penable && pwrite && pwdata[0]
                      && paddr == {2'h3, ecl_pkg::OFF_CTRL};
    always_ff @(posedge clk)
    begin
        if (!resetn)
            w64_r <= 16'h0000;
        else if (word_valid && loading && word_addr == ecl_pkg::WA_SLOT_P2)
            w64_r <= word_data;
        else if (reload_w)
            w64_r <= 16'h0000;
    end

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
    property p_ready_access;
        pready |-> psel && penable;
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("stray pready");
    property p_stall;
        psel && penable && paddr[11:10] != 2'h3 && loading |-> !pready;
    endproperty
    a_stall: assert property (p_stall) else $error("read before load done");
    property p_ready_bound;
        psel && penable && !loading && !pready |-> ##[1:2] pready;
    endproperty
    a_ready_bound: assert property (p_ready_bound) else $error("late pready");
    property p_load_end;
        loading && load_end && !reload_w |=> !loading;
    endproperty
    a_load_end: assert property (p_load_end) else $error("loading stuck");
    property p_done_holds;
        !loading && !reload_w |=> !loading;
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("loading rose");
    property p_slverr;
        pslverr |-> pready && paddr[11:10] == 2'h3;
    endproperty
    a_slverr: assert property (p_slverr) else $error("bad pslverr");
    property p_idle_data;
        !pready |-> prdata == 32'h00000000;
    endproperty
    a_idle_data: assert property (p_idle_data) else $error("prdata not zero");
    property p_slotcap;
        pready && !pwrite && paddr == {2'h2, ecl_pkg::CFG_SLOTCAP}
            |-> prdata == {7'h00, w64_r[0], 24'h000000};
    endproperty
    a_slotcap: assert property (p_slotcap) else $error("slot flag wrong");
    property p_portnum;
        pready && !pwrite && paddr == {2'h2, ecl_pkg::CFG_PORTNUM}
            |-> prdata == {5'h00, w64_r[6:4], 24'h000000};
    endproperty
    a_portnum: assert property (p_portnum) else $error("port number wrong");
endmodule
`default_nettype wire

// >>> ecl_eeprom_model.sv
`timescale 1ns/1ns
`default_nettype none
module ecl_eeprom_model
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // pass control from the bench
    input  wire logic        start,
    input  wire logic        slow,
    // word stream towards the loader
    output logic             word_valid,
    output logic      [7:0]  word_addr,
    output logic      [15:0] word_data,
    output logic             load_end
);
    // bit 16 marks a programmed location; blank ones send nothing
    logic [16:0] mem [0:255];
    // one pass walks the block in order; idle word_data toggles so stale data never looks valid
    initial
    begin
        word_valid = 1'b0;
        load_end = 1'b0;
        word_addr = 8'h00;
        word_data = 16'h0000;
        forever
        begin
            @(posedge clk);
            if (start && resetn)
            begin
                for (int a = 8'h5E; a <= 8'h86; a += 2)
                begin
                    if (mem[a][16])
                    begin
                        word_valid <= 1'b1;
                        word_addr <= a[7:0];
                        word_data <= mem[a][15:0];
                    end
                    else
                    begin
                        word_valid <= 1'b0;
                        word_data <= ~word_data;
                    end
                    @(posedge clk);
                    if (slow)
                    begin
                        word_valid <= 1'b0;
                        word_data <= ~word_data;
                        repeat (2) @(posedge clk);
                    end
                end
                word_valid <= 1'b0;
                word_data <= ~word_data;
                load_end <= 1'b1;
                @(posedge clk);
                load_end <= 1'b0;
            end
            else
                word_data <= ~word_data;
        end
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // design and model hookup
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic        start, slow, word_valid, load_end, loading;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic [7:0]  word_addr, mk, cnt;
    logic [15:0] word_data;
    logic [32:0] exq [$];
    logic [31:0] e;
    int          failures, checks;
    logic [9:0]  offs [11] = '{ecl_pkg::CFG_PMCAP, ecl_pkg::CFG_VGA, ecl_pkg::CFG_PMCTL,
        ecl_pkg::CFG_VTUNE, ecl_pkg::CFG_SLOTCAP, ecl_pkg::CFG_PORTNUM, ecl_pkg::CFG_SLOTCLK,
        ecl_pkg::CFG_LPVC, ecl_pkg::CFG_TCMAP, ecl_pkg::CFG_PBUDGET, ecl_pkg::CFG_PBALLOC};
    logic [7:0]  hs [8] = '{8'h62, 8'h64, 8'h70, 8'h72, 8'h74, 8'h80, 8'h82, 8'h84};

    ecl_loader dut (.clk, .resetn, .word_valid, .word_addr, .word_data, .load_end, .loading,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
    ecl_eeprom_model mem_model (.clk, .resetn, .start, .slow, .word_valid, .word_addr,
        .word_data, .load_end);

    // free-running core clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    // a blank location reads as an all-zero word
    function automatic logic [15:0] w(input logic [7:0] a);
        return mem_model.mem[a][16] ? mem_model.mem[a][15:0] : 16'h0000;
    endfunction

    // expected register image, built field by field from the memory contents
    function automatic logic [31:0] exp_f(input logic [1:0] p, input logic [9:0] off);
        logic [15:0] s, t, b, m;
        s = (p == 2'h2) ? w(8'h64) : 16'h0000;
        t = (p == 2'h1) ? w(8'h62) : s;
        b = w(8'h70 + {p, 1'b0});
        m = w(8'h80 + {p, 1'b0});
        case (off)
            ecl_pkg::CFG_PMCAP:   return {10'h000, s[2], 21'h000000};
            ecl_pkg::CFG_VGA:     return {m[7], 31'h00000000};
            ecl_pkg::CFG_PMCTL:   return {17'h00000, m[6], m[5:0], 8'h00};
            ecl_pkg::CFG_VTUNE:   return {m[15:8], 24'h000000};
            ecl_pkg::CFG_SLOTCAP: return {7'h00, s[0], 24'h000000};
            ecl_pkg::CFG_PORTNUM: return {5'h00, s[6:4], 24'h000000};
            ecl_pkg::CFG_SLOTCLK: return {3'h0, s[1], 28'h0000000};
            ecl_pkg::CFG_LPVC:    return {27'h0000000, s[3], 4'h0};
            ecl_pkg::CFG_TCMAP:   return {24'h000000, t[15:9], 1'b0};
            ecl_pkg::CFG_PBUDGET: return {17'h00000, b[11:10], 3'h0, b[9:8], b[7:0]};
            ecl_pkg::CFG_PBALLOC: return {31'h00000000, b[15]};
            default:              return 32'h00000000;
        endcase
    endfunction

    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 5000);
        if (n >= 5000)
        begin
            failures++;
            $display("mismatch at %0t: no pready", $time);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic err);
        exq.push_back({err, x});
        apb(1'b0, a, 32'h00000000);
    endtask

    // read results are matched against the oldest note
    task automatic cmp(input logic [31:0] d, input logic err);
        logic [32:0] x;
        checks++;
        x = (exq.size() > 0) ? exq.pop_front() : 33'h000000000;
        if (x[32] ? (err !== 1'b1) : ({err, d} !== x))
        begin
            failures++;
            $display("mismatch at %0t: got %h/%h want %h", $time, err, d, x);
        end
    endtask

    // response monitor
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp(prdata, pslverr);
    end

    // watchdog: a full run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("mismatch at %0t: timeout", $time);
        conclude();
    end

    // three loads: plain, slow with blanks, fast with blanks after reload
    initial
    begin
        {resetn, psel, penable, pwrite, start, slow} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        rnd = 32'h65B2;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int r = 0; r < 3; r++)
        begin
            if (r > 0)
                apb(1'b1, {2'h3, ecl_pkg::OFF_CTRL}, 32'h00000001);
            rd({2'h3, ecl_pkg::OFF_STATUS}, 32'h00000001, 1'b0);
            rd({2'h3, 10'h008}, 32'h00000000, 1'b1);
            for (int a = 8'h5E; a <= 8'h86; a += 2)
            begin
                rnd = xs(rnd);
                mem_model.mem[a] = {r == 0 || rnd[31], rnd[15:0]};
            end
            slow <= r[0];
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            for (int p = 0; p < 3; p++)
                for (int i = 0; i < 11; i++)
                begin
                    e = exp_f(p[1:0], offs[i]);
                    rd({p[1:0], offs[i]}, e, 1'b0);
                end
            apb(1'b1, {2'h0, ecl_pkg::CFG_PBUDGET}, rnd);
            rd({2'h0, ecl_pkg::CFG_PBUDGET}, exp_f(2'h0, ecl_pkg::CFG_PBUDGET), 1'b0);
            mk = 8'h00;
            cnt = 8'h00;
            for (int i = 0; i < 8; i++)
            begin
                mk[i] = mem_model.mem[hs[i]][16];
                cnt = cnt + {7'h00, mk[i]};
            end
            rd({2'h3, ecl_pkg::OFF_STATUS}, {8'h00, cnt, mk, 8'h00}, 1'b0);
            $display("load round %0d done", r);
        end
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule

bind ecl_loader ecl_loader_props u_props (.clk, .resetn, .word_valid, .word_addr, .word_data,
    .load_end, .loading, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
`default_nettype wire
